// ---- hdl/debug_pin_mux_pkg.sv ----
// constants shared by the debug pin multiplexer files
package debug_pin_mux_pkg;

	// ------------------------------------------------------------
	// pin indices
	// ------------------------------------------------------------
	localparam int NUM_PINS        = 5;
	localparam int NUM_SAMPLED     = 6;
	localparam int PIN_PORT_A_BIT0 = 0;
	localparam int PIN_PORT_A_BIT1 = 1;
	localparam int PIN_PORT_A_BIT2 = 2;
	localparam int PIN_PORT_A_BIT3 = 3;
	localparam int PIN_PORT_B_BIT0 = 4;
	localparam int SMP_EXT_RESET_N = 5;

	// ------------------------------------------------------------
	// per-pin settings field layout
	// ------------------------------------------------------------
	localparam int CFG_W        = 6;
	localparam int F_FUNC_SEL   = 0;
	localparam int F_INPUT_EN   = 1;
	localparam int F_OUTPUT_CTL = 2;
	localparam int F_PULLUP     = 3;
	localparam int F_PULLDOWN   = 4;
	localparam int F_DATA_OUT   = 5;

	// reset values: {data, pdn, pup, cr, ie, fr}
	localparam logic [5:0] RST_PORT_A_BIT0 = 6'h0f;
	localparam logic [5:0] RST_PORT_A_BIT1 = 6'h13;
	localparam logic [5:0] RST_PORT_A_BIT2 = 6'h00;
	localparam logic [5:0] RST_PORT_A_BIT3 = 6'h00;
	localparam logic [5:0] RST_PORT_B_BIT0 = 6'h05;
	localparam logic       RST_STBY_DRIVE  = 1'b0;

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] OFS_CFG_BASE = 8'h00;
	localparam logic [7:0] OFS_STANDBY  = 8'h14;
	localparam logic [7:0] OFS_STATUS   = 8'h18;
	localparam int         ST_PIN_LSB   = 0;
	localparam int         ST_MODE_LSB  = 8;
	localparam int         ST_EXT_RST   = 12;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// debug pin usage modes
	typedef enum logic [1:0] {
		MODE_SW_VIEWER,
		MODE_SW_ONLY,
		MODE_SW_TRACE,
		MODE_DISABLED
	} dbg_mode_t;

endpackage

// ---- hdl/pin_sample_if.sv ----
// carrier between the multiplexer and its input sampler
`timescale 1ns/100ps
`default_nettype none
interface pin_sample_if;
	logic [5:0] raw;
	logic [5:0] level;
	modport sampler (input raw, output level);
	modport user    (output raw, input level);
endinterface
`default_nettype wire

// ---- hdl/pin_sampler.sv ----
// three-stage sampler for pin inputs from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module pin_sampler (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	pin_sample_if.sampler    smp
);
	logic [5:0] s1_q, s2_q, s3_q, level_q;
	logic [5:0] s1_d, s2_d, s3_d, level_d;

	always_comb begin
		s1_d = smp.raw;
		s2_d = s1_q;
		s3_d = s2_q;
		level_d = level_q;
		for (int i = 0; i < 6; i++) begin
			// a change counts only once stages two and three agree
			if (s2_q[i] == s3_q[i]) begin
				level_d[i] = s3_q[i];
			end
		end
	end

	// resets low: external reset reads as held until the pin is seen
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q    <= 6'h00;
			s2_q    <= 6'h00;
			s3_q    <= 6'h00;
			level_q <= 6'h00;
		end else begin
			s1_q    <= s1_d;
			s2_q    <= s2_d;
			s3_q    <= s3_d;
			level_q <= level_d;
		end
	end

	assign smp.level = level_q;
endmodule
`default_nettype wire

// ---- hdl/debug_pin_mux.sv ----
// debug pin multiplexer with axi4-lite settings registers
//
// Contract
// - After reset port A bits 0 and 1 and port B bit 0 are debug pins.
// - Data goes to port A bit 0 both ways, clock in on port A bit 1, trace clock and data out on port A bits 2 and 3.
// - Trace clock and data pins reset to general use until software sets them.
// - Each pin's settings take the documented reset values.
// - The viewer pin drives trace output only while its viewer function is on.
// - Data and viewer pins keep driving in stop mode whatever the standby drive bit says.
// - Trace offers one data bit, one clock and the viewer output.
// - Trace data is routed to the trace data pin only; the viewer pin carries viewer data.
// - Every debug pin may be selected as an ordinary port pin instead.
// - No debug traffic is accepted while the external reset pin is held.
// - Four usage modes exist, with serial wire plus viewer the default.
`timescale 1ns/100ps
`default_nettype none
module debug_pin_mux (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [4:0]  pin_in,
	output logic [4:0]       pin_out,
	output logic [4:0]       pin_oe,
	output logic [4:0]       pin_pullup,
	output logic [4:0]       pin_pulldown,
	input  wire logic        ext_reset_pin_n,
	input  wire logic        stop_mode,
	input  wire logic        swdio_drive_val,
	input  wire logic        swdio_drive_en,
	input  wire logic        trace_clock_src,
	input  wire logic        trace_data_src,
	input  wire logic        viewer_data_src,
	output logic             swdio_rx,
	output logic             swclk_rise,
	output logic             debug_link_enable,
	output logic [1:0]       debug_mode
);
	// ------------------------------------------------------------
	// input sampling
	// ------------------------------------------------------------
	pin_sample_if smp ();
	assign smp.raw = {ext_reset_pin_n, pin_in};

	pin_sampler u_sampler (
		.aclk    (aclk),
		.aresetn (aresetn),
		.smp     (smp.sampler)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] merge_strobe(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb
	);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// index of a settings register, or NUM_PINS when not one
	function automatic int cfg_index(input logic [7:0] addr);
		int r;
		r = debug_pin_mux_pkg::NUM_PINS;
		for (int i = 0; i < debug_pin_mux_pkg::NUM_PINS; i++) begin
			if (addr == debug_pin_mux_pkg::OFS_CFG_BASE + 8'(i * 4)) begin
				r = i;
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// register and bus state
	// ------------------------------------------------------------
	logic [5:0]  cfg_q [5];
	logic [5:0]  cfg_d [5];
	logic        stby_drive_q, stby_drive_d;
	logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        awready_q, awready_d, wready_q, wready_d;
	logic        bvalid_q, bvalid_d, arready_q, arready_d;
	logic        rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] status_w;
	logic        ext_rst_held;
	logic        link_en;
	debug_pin_mux_pkg::dbg_mode_t mode_w;

	assign ext_rst_held = ~smp.level[debug_pin_mux_pkg::SMP_EXT_RESET_N];

	// ------------------------------------------------------------
	// usage mode and link gating
	// ------------------------------------------------------------
	// mode from function bits
	always_comb begin
		if (!(cfg_q[0][debug_pin_mux_pkg::F_FUNC_SEL] &&
		      cfg_q[1][debug_pin_mux_pkg::F_FUNC_SEL])) begin
			mode_w = debug_pin_mux_pkg::MODE_DISABLED;
		end else if (cfg_q[2][debug_pin_mux_pkg::F_FUNC_SEL] &&
		             cfg_q[3][debug_pin_mux_pkg::F_FUNC_SEL]) begin
			mode_w = debug_pin_mux_pkg::MODE_SW_TRACE;
		end else if (cfg_q[4][debug_pin_mux_pkg::F_FUNC_SEL]) begin
			mode_w = debug_pin_mux_pkg::MODE_SW_VIEWER;
		end else begin
			mode_w = debug_pin_mux_pkg::MODE_SW_ONLY;
		end
	end

	assign link_en = (mode_w != debug_pin_mux_pkg::MODE_DISABLED)
	                 && !ext_rst_held;

	always_comb begin
		status_w = 32'h0000_0000;
		for (int i = 0; i < debug_pin_mux_pkg::NUM_PINS; i++) begin
			status_w[debug_pin_mux_pkg::ST_PIN_LSB + i] = smp.level[i] &
				cfg_q[i][debug_pin_mux_pkg::F_INPUT_EN];
		end
		status_w[debug_pin_mux_pkg::ST_MODE_LSB +: 2] = mode_w;
		status_w[debug_pin_mux_pkg::ST_EXT_RST] = ext_rst_held;
	end

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	always_comb begin
		logic [31:0] merged;
		int          wi;
		int          ri;
		merged       = 32'h0000_0000;
		wi           = cfg_index(awaddr_q);
		ri           = cfg_index(s_axi_araddr);
		cfg_d        = cfg_q;
		stby_drive_d = stby_drive_q;
		aw_held_d    = aw_held_q;
		w_held_d     = w_held_q;
		awaddr_d     = awaddr_q;
		wdata_d      = wdata_q;
		wstrb_d      = wstrb_q;
		bvalid_d     = bvalid_q;
		bresp_d      = bresp_q;
		rvalid_d     = rvalid_q;
		rresp_d      = rresp_q;
		rdata_d      = rdata_q;
		arready_d    = arready_q;
		if (s_axi_awvalid && awready_q) begin
			aw_held_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_held_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (aw_held_q && w_held_q && !bvalid_q) begin
			aw_held_d = 1'b0;
			w_held_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = debug_pin_mux_pkg::RESP_OKAY;
			if (wi < debug_pin_mux_pkg::NUM_PINS) begin
				// any pin may go general use
				merged = merge_strobe({26'h0, cfg_q[wi]}, wdata_q, wstrb_q);
				cfg_d[wi] = merged[5:0];
			end else if (awaddr_q == debug_pin_mux_pkg::OFS_STANDBY) begin
				merged = merge_strobe({31'h0, stby_drive_q}, wdata_q,
				                      wstrb_q);
				stby_drive_d = merged[0];
			end else if (awaddr_q == debug_pin_mux_pkg::OFS_STATUS) begin
				bresp_d = debug_pin_mux_pkg::RESP_OKAY;
			end else begin
				bresp_d = debug_pin_mux_pkg::RESP_SLVERR;
			end
		end
		if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rresp_d   = debug_pin_mux_pkg::RESP_OKAY;
			if (ri < debug_pin_mux_pkg::NUM_PINS) begin
				rdata_d = {26'h0, cfg_q[ri]};
			end else if (s_axi_araddr == debug_pin_mux_pkg::OFS_STANDBY) begin
				rdata_d = {31'h0, stby_drive_q};
			end else if (s_axi_araddr == debug_pin_mux_pkg::OFS_STATUS) begin
				rdata_d = status_w;
			end else begin
				rdata_d = 32'h0000_0000;
				rresp_d = debug_pin_mux_pkg::RESP_SLVERR;
			end
		end
		awready_d = !aw_held_d;
		wready_d  = !w_held_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_q[0]     <= debug_pin_mux_pkg::RST_PORT_A_BIT0;
			cfg_q[1]     <= debug_pin_mux_pkg::RST_PORT_A_BIT1;
			cfg_q[2]     <= debug_pin_mux_pkg::RST_PORT_A_BIT2;
			cfg_q[3]     <= debug_pin_mux_pkg::RST_PORT_A_BIT3;
			cfg_q[4]     <= debug_pin_mux_pkg::RST_PORT_B_BIT0;
			stby_drive_q <= debug_pin_mux_pkg::RST_STBY_DRIVE;
			aw_held_q    <= 1'b0;
			w_held_q     <= 1'b0;
			awaddr_q     <= 8'h00;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			awready_q    <= 1'b0;
			wready_q     <= 1'b0;
			bvalid_q     <= 1'b0;
			bresp_q      <= 2'h0;
			arready_q    <= 1'b0;
			rvalid_q     <= 1'b0;
			rresp_q      <= 2'h0;
			rdata_q      <= 32'h0000_0000;
		end else begin
			cfg_q        <= cfg_d;
			stby_drive_q <= stby_drive_d;
			aw_held_q    <= aw_held_d;
			w_held_q     <= w_held_d;
			awaddr_q     <= awaddr_d;
			wdata_q      <= wdata_d;
			wstrb_q      <= wstrb_d;
			awready_q    <= awready_d;
			wready_q     <= wready_d;
			bvalid_q     <= bvalid_d;
			bresp_q      <= bresp_d;
			// ready rises one edge after reset release
			arready_q    <= arready_d | (!rvalid_d && !arready_q &&
			                              !rvalid_q);
			rvalid_q     <= rvalid_d;
			rresp_q      <= rresp_d;
			rdata_q      <= rdata_d;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	// ------------------------------------------------------------
	// pin drivers and debug link
	// ------------------------------------------------------------
	logic [4:0] out_q, out_d, oe_q, oe_d, pu_q, pu_d, pd_q, pd_d;
	logic       swclk_prev_q, swclk_prev_d, rise_q, rise_d;
	logic       rx_q, rx_d, link_q, link_d;
	logic [1:0] mode_q, mode_d;
	logic       drive_ok;

	// stop mode cuts ordinary drivers unless standby drive is set
	assign drive_ok = !stop_mode || stby_drive_q;

	always_comb begin
		for (int i = 0; i < debug_pin_mux_pkg::NUM_PINS; i++) begin
			pu_d[i] = cfg_q[i][debug_pin_mux_pkg::F_PULLUP];
			pd_d[i] = cfg_q[i][debug_pin_mux_pkg::F_PULLDOWN];
			out_d[i] = cfg_q[i][debug_pin_mux_pkg::F_DATA_OUT];
			oe_d[i]  = cfg_q[i][debug_pin_mux_pkg::F_OUTPUT_CTL] && drive_ok;
			if (cfg_q[i][debug_pin_mux_pkg::F_FUNC_SEL]) begin
				case (i)
				debug_pin_mux_pkg::PIN_PORT_A_BIT0: begin
					out_d[i] = swdio_drive_val;
					oe_d[i]  = swdio_drive_en && link_en;
				end
				debug_pin_mux_pkg::PIN_PORT_A_BIT1: begin
					out_d[i] = 1'b0;
					oe_d[i]  = 1'b0;
				end
				debug_pin_mux_pkg::PIN_PORT_A_BIT2: begin
					out_d[i] = trace_clock_src;
					oe_d[i]  = drive_ok;
				end
				debug_pin_mux_pkg::PIN_PORT_A_BIT3: begin
					out_d[i] = trace_data_src;
					oe_d[i]  = drive_ok;
				end
				default: begin
					out_d[i] = viewer_data_src;
					oe_d[i]  = 1'b1;
				end
				endcase
			end
		end
		swclk_prev_d = smp.level[debug_pin_mux_pkg::PIN_PORT_A_BIT1];
		rise_d = link_en && swclk_prev_d && !swclk_prev_q;
		rx_d   = smp.level[debug_pin_mux_pkg::PIN_PORT_A_BIT0];
		// general clock pin stops the link
		link_d = link_en;
		mode_d = mode_w;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q        <= 5'h00;
			oe_q         <= 5'h00;
			pu_q         <= 5'h00;
			pd_q         <= 5'h00;
			swclk_prev_q <= 1'b0;
			rise_q       <= 1'b0;
			rx_q         <= 1'b0;
			link_q       <= 1'b0;
			mode_q       <= 2'h0;
		end else begin
			out_q        <= out_d;
			oe_q         <= oe_d;
			pu_q         <= pu_d;
			pd_q         <= pd_d;
			swclk_prev_q <= swclk_prev_d;
			rise_q       <= rise_d;
			rx_q         <= rx_d;
			link_q       <= link_d;
			mode_q       <= mode_d;
		end
	end

	assign pin_out           = out_q;
	assign pin_oe            = oe_q;
	assign pin_pullup        = pu_q;
	assign pin_pulldown      = pd_q;
	assign swclk_rise        = rise_q;
	assign swdio_rx          = rx_q;
	assign debug_link_enable = link_q;
	assign debug_mode        = mode_q;
endmodule
`default_nettype wire

// ---- tb/debug_pin_mux_properties.sv ----
// port checker for the debug pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module debug_pin_mux_properties (
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic [4:0] pin_oe,
	input wire logic [4:0] pin_pullup,
	input wire logic [4:0] pin_pulldown,
	input wire logic       ext_reset_pin_n,
	input wire logic       swclk_rise,
	input wire logic       debug_link_enable
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rst_cfg;
		pin_pullup == 5'h01 && pin_pulldown == 5'h02
			&& pin_oe[4] && pin_oe[3:2] == 2'h0;
	endsequence

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_wr_resp;
		s_wr_take |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write late");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read late");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("ar open");
	property p_rst_cfg;
		$rose(aresetn) |-> ##[1:2] s_rst_cfg;
	endproperty
	a_rst_cfg: assert property (p_rst_cfg) else $error("bad reset pins");
	property p_ext_link;
		!ext_reset_pin_n [*8] |-> !debug_link_enable;
	endproperty
	a_ext_link: assert property (p_ext_link) else $error("link on");
	property p_ext_pin0;
		!ext_reset_pin_n [*8] |-> !pin_oe[0];
	endproperty
	a_ext_pin0: assert property (p_ext_pin0) else $error("data driven");
	property p_rise_one;
		swclk_rise |=> !swclk_rise;
	endproperty
	a_rise_one: assert property (p_rise_one) else $error("long pulse");
	property p_rise_link;
		swclk_rise |-> debug_link_enable;
	endproperty
	a_rise_link: assert property (p_rise_link) else $error("rise no link");
endmodule
bind debug_pin_mux debug_pin_mux_properties u_debug_pin_mux_properties (.*);
`default_nettype wire

// ---- tb/debug_probe_model.sv ----
// external probe: serial clock and data toward the device pads
`timescale 1ns/100ps
`default_nettype none
module debug_probe_model (
	input  wire logic dio_oe,
	input  wire logic dio_out,
	output var logic  swclk,
	output wire logic swdio
);
	logic drive;
	logic bit_v;

	// data both ways
	// a released line settles to the pad pull-up, not the last bit
	assign swdio = dio_oe ? dio_out : (drive ? bit_v : 1'b1);

	initial begin
		swclk = 1'b0;
		drive = 1'b0;
		bit_v = 1'b0;
	end

	// clock only runs inside a frame, phase unrelated to aclk
	task automatic frame(input logic [7:0] b);
		#7;
		for (int i = 7; i >= 0; i--) begin
			drive = 1'b1;
			bit_v = b[i];
			#100 swclk = 1'b1;
			#100 swclk = 1'b0;
		end
		drive = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- tb/debug_pin_mux_test.sv ----
// register-driven bench for the debug pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module debug_pin_mux_test;
	logic        aclk, aresetn, stop_mode, ext_reset_pin_n, swclk, swdio;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, swdio_rx, swclk_rise;
	logic        swdio_drive_val, swdio_drive_en, trace_clock_src;
	logic        trace_data_src, viewer_data_src, debug_link_enable;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, debug_mode, rsp;
	logic [4:0]  pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown;
	int          miscompares, total_checks, rises, r0;
	localparam logic [5:0] rst_vals [6] = '{6'h0f, 6'h13, 6'h00, 6'h00,
		6'h05, 6'h00};

	// trace pads read back what they drive
	assign pin_in = {pin_oe[4:2] & pin_out[4:2], swclk, swdio};

	debug_pin_mux u_debug_pin_mux (.*);
	debug_probe_model u_probe (.dio_oe(pin_oe[0]), .dio_out(pin_out[0]),
		.swclk(swclk), .swdio(swdio));

	always #12.5 aclk = ~aclk;
	always @(posedge aclk) if (swclk_rise === 1'b1) rises <= rises + 1;

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tmo;
		miscompares++;
		$display("Error at %0t: bus wait ran out", $time);
		results();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s, input logic [1:0] er);
		logic ha, hw, hb;
		hb = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 40 && !hb; n++) begin
			@(negedge aclk);
			ha = s_axi_awvalid & s_axi_awready;
			hw = s_axi_wvalid & s_axi_wready;
			hb = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (ha) s_axi_awvalid <= 1'b0;
			if (hw) s_axi_wvalid <= 1'b0;
			if (hb) s_axi_bready <= 1'b0;
		end
		if (hb !== 1'b1) tmo();
		chk(rsp, er);
		repeat (3) @(posedge aclk);
	endtask
	task automatic rdr(input logic [7:0] a, input logic [1:0] er);
		logic ha, hr;
		hr = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 40 && !hr; n++) begin
			@(negedge aclk);
			ha = s_axi_arvalid & s_axi_arready;
			hr = s_axi_rvalid;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ha) s_axi_arvalid <= 1'b0;
			if (hr) s_axi_rready <= 1'b0;
		end
		if (hr !== 1'b1) tmo();
		chk(rsp, er);
	endtask

	// ------------------------------------------------------------
	// sequence of tests
	// ------------------------------------------------------------
	initial begin
		{aclk, aresetn, stop_mode, ext_reset_pin_n, s_axi_awvalid,
			s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
			swdio_drive_val, swdio_drive_en, trace_clock_src,
			trace_data_src, viewer_data_src} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{miscompares, total_checks, rises} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(pin_oe[4], 1);
		chk(pin_oe[3:2], 0);
		chk(debug_mode, debug_pin_mux_pkg::MODE_SW_VIEWER);
		for (int i = 0; i < 6; i++) begin
			rdr(8'(4 * i), 2'h0);
			chk(rd, {26'h0, rst_vals[i]});
		end
		r0 = rises;
		u_probe.frame(8'ha5);
		chk(rises - r0, 0);
		ext_reset_pin_n <= 1'b1;
		repeat (10) @(posedge aclk);
		chk(debug_link_enable, 1);
		r0 = rises;
		u_probe.frame(8'h5a);
		repeat (8) @(posedge aclk);
		chk(rises - r0, 8);
		chk(swdio_rx, 1);
		swdio_drive_en <= 1'b1;
		swdio_drive_val <= 1'b1;
		stop_mode <= 1'b1;
		viewer_data_src <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({pin_oe[0], pin_out[0], pin_oe[4]}, 3'h7);
		swdio_drive_val <= 1'b0;
		repeat (3) @(posedge aclk);
		chk({pin_oe[0], pin_out[0], pin_oe[4]}, 3'h5);
		chk(pin_out[4], 1);
		ext_reset_pin_n <= 1'b0;
		repeat (10) @(posedge aclk);
		chk(pin_oe[0], 0);
		ext_reset_pin_n <= 1'b1;
		stop_mode <= 1'b0;
		trace_clock_src <= 1'b1;
		wr(8'h08, 32'h05, 4'hf, 2'h0);
		wr(8'h0c, 32'h05, 4'hf, 2'h0);
		chk(debug_mode, debug_pin_mux_pkg::MODE_SW_TRACE);
		chk({pin_oe[3:2], pin_out[3:2]}, 4'hd);
		trace_clock_src <= 1'b0;
		trace_data_src <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(pin_out[3:2], 2'h2);
		wr(8'h0c, 32'h00, 4'hf, 2'h0);
		viewer_data_src <= 1'b0;
		wr(8'h10, 32'h00, 4'hf, 2'h0);
		chk(pin_oe[4], 0);
		chk(debug_mode, debug_pin_mux_pkg::MODE_SW_ONLY);
		wr(8'h10, 32'h24, 4'hf, 2'h0);
		chk({pin_oe[4], pin_out[4]}, 2'h3);
		// clock pin handed back to port use when debug is idle
		wr(8'h04, 32'h02, 4'hf, 2'h0);
		chk(debug_mode, debug_pin_mux_pkg::MODE_DISABLED);
		wr(8'h00, 32'h24, 4'h1, 2'h0);
		chk({pin_oe[0], pin_out[0]}, 2'h3);
		wr(8'h00, 32'h00, 4'h0, 2'h0);
		chk(pin_out[0], 1);
		r0 = rises;
		u_probe.frame(8'h3c);
		chk(rises - r0, 0);
		wr(8'h1c, 32'h01, 4'hf, 2'h2);
		rdr(8'h1c, 2'h2);
		chk(rd, 0);
		rdr(8'h18, 2'h0);
		chk(rd[9:8], 2'h3);
		results();
	end
endmodule
`default_nettype wire
